// file: hdl/ssc_core.sv
// Control two, control three and sync pattern logic of the serial adapter,
// with sync hunt, fill insertion and error interrupt gating.
// Assumes host bus strobes are on sys_clk; serial pins are asynchronous.
//
// Contract
// - Control two written when both address bits zero
// - Match mode pulses output on each match while level bit low
// - Match pulse timed from receive clock fall
// - Terminal-ready mode drives inverse of level bit
// - Transfer-size bit picks one or two bytes
// - Word length bits give 7, 8, 9 bits
// - Word length code decoded per format table
// - Underflow sends sync code or all ones
// - Underflow pulse only when sync fill set
// - No fill parity except nine-bit sync fill
// - Error enable raises interrupt on five events
// - CTS and underflow cleared by command; carrier and overrun by status-then-FIFO read
// - Error enable low masks; reset clears it
// - Control three written at address code 01
// - External sync disables hunt; reset clears it
// - External mode: inhibit by bus, pattern kept
// - One or two sync characters declare sync
// - Clear-CTS command clears stored status, self-clears
// - Clear-underflow command clears status, self-clears
// - Sync pattern written at address code 10
// - Match output high one bit at boundary
// - Sync character parity only in nine-bit format
// - Sync-establishing characters discarded, not checked
// - After sync, strip or pass with parity
`timescale 1ns/100ps
`include "ssc_regs.svh"

module ssc_core (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Host bus, one-cycle enable strobe
	input wire logic bus_enable,
	input wire logic reg_select,
	input wire logic read_write,
	input wire logic [7:0] bus_data_in,
	// Control one bits
	input wire logic addr_ctl_low,
	input wire logic addr_ctl_high,
	input wire logic strip_sync_in,
	input wire logic clear_sync_in,
	input wire logic tx_section_reset,
	input wire logic rx_section_reset,
	// Status and FIFO side
	input wire logic status_read_stb,
	input wire logic rx_fifo_read_stb,
	input wire logic rx_overrun_evt,
	input wire logic rx_last_par_err,
	input wire logic tx_slot1_empty,
	input wire logic tx_slot2_empty,
	input wire logic rx_slot2_full,
	input wire logic rx_slot3_full,
	input wire logic tx_fifo_valid,
	input wire logic [7:0] tx_fifo_data,
	output logic tx_fifo_take,
	output logic rx_char_valid,
	output logic [7:0] rx_char_data,
	output logic rx_char_par_err,
	// Serial pins
	input wire logic rx_clk_pin,
	input wire logic rx_data_pin,
	input wire logic tx_clk_pin,
	input wire logic carrier_detect_in,
	input wire logic clear_to_send_in,
	output logic tx_data_out,
	output logic match_or_terminal_ready_out,
	output logic tx_underflow,
	// Status view
	output logic tx_room_flag,
	output logic rx_avail_flag,
	output logic carrier_status,
	output logic cts_status,
	output logic underflow_status,
	output logic overrun_status,
	output logic error_irq_status,
	output logic error_irq_b
);

	// Word length code, high bit first
	function automatic ssc_pkg::ssc_fmt_t fmt_decode(input logic [2:0] code);
		ssc_pkg::ssc_fmt_t f;
		f = '{data_bits: 4'h8, par_en: 1'b0, par_odd: 1'b0};
		case (code)
			3'h0: f = '{data_bits: 4'h6, par_en: 1'b1, par_odd: 1'b0};
			3'h1: f = '{data_bits: 4'h6, par_en: 1'b1, par_odd: 1'b1};
			3'h2: f = '{data_bits: 4'h7, par_en: 1'b0, par_odd: 1'b0};
			3'h3: f = '{data_bits: 4'h8, par_en: 1'b0, par_odd: 1'b0};
			3'h4: f = '{data_bits: 4'h7, par_en: 1'b1, par_odd: 1'b0};
			3'h5: f = '{data_bits: 4'h7, par_en: 1'b1, par_odd: 1'b1};
			3'h6: f = '{data_bits: 4'h8, par_en: 1'b1, par_odd: 1'b0};
			3'h7: f = '{data_bits: 4'h8, par_en: 1'b1, par_odd: 1'b1};
			default: f = '{data_bits: 4'h8, par_en: 1'b0, par_odd: 1'b0};
		endcase
		return f;
	endfunction

	// Low n bits set
	function automatic logic [7:0] bit_mask(input logic [3:0] n);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 8; i++) begin
			m[i] = (4'(i) < n);
		end
		return m;
	endfunction

	// Data with its parity bit placed above it
	function automatic logic [8:0] build_char(input logic [7:0] d,
			input ssc_pkg::ssc_fmt_t f);
		logic [7:0] md;
		logic [8:0] w;
		md = d & bit_mask(f.data_bits);
		w = {1'b0, md};
		if (f.par_en) begin
			w[f.data_bits] = (^md) ^ f.par_odd;
		end
		return w;
	endfunction

	// Registers
	logic [7:0] control_two_format_reg;
	logic [1:0] control_three_sync_mode_reg;
	logic [7:0] sync_pattern_reg;

	// Format decode
	ssc_pkg::ssc_fmt_t fmt;
	logic [3:0] char_len;
	logic [3:0] cmp_len;
	logic match_mode_select;
	logic output_level_ctl;
	logic one_byte;
	logic tx_sync_fill;
	logic error_irq_enable;
	logic ext_sync;
	logic one_sync;

	assign fmt = fmt_decode(control_two_format_reg[`SSC_C2_WLEN_HI:`SSC_C2_WLEN_LO]);
	assign char_len = fmt.data_bits + {3'h0, fmt.par_en};
	assign cmp_len = (char_len > `SSC_MAX_DATA) ? `SSC_MAX_DATA : char_len;
	assign match_mode_select = control_two_format_reg[`SSC_C2_MATCH_MODE];
	assign output_level_ctl = control_two_format_reg[`SSC_C2_OUT_LEVEL];
	assign one_byte = control_two_format_reg[`SSC_C2_ONE_BYTE];
	assign tx_sync_fill = control_two_format_reg[`SSC_C2_TX_SYNC_FILL];
	assign error_irq_enable = control_two_format_reg[`SSC_C2_ERR_IRQ_EN];
	assign ext_sync = control_three_sync_mode_reg[`SSC_C3_EXT_SYNC];
	assign one_sync = control_three_sync_mode_reg[`SSC_C3_ONE_SYNC];

	// Write decode
	logic bus_wr;
	logic [1:0] wr_sel;
	logic wr_c2;
	logic wr_c3;
	logic wr_sync;
	logic clr_cts_cmd;
	logic clear_underflow_cmd;

	assign bus_wr = bus_enable & reg_select & ~read_write;
	assign wr_sel = {addr_ctl_high, addr_ctl_low};
	assign wr_c2 = bus_wr & (wr_sel == `SSC_SEL_CTRL2);
	assign wr_c3 = bus_wr & (wr_sel == `SSC_SEL_CTRL3);
	assign wr_sync = bus_wr & (wr_sel == `SSC_SEL_SYNC);
	// Command bits act only as write pulses, never stored
	assign clr_cts_cmd = wr_c3 & bus_data_in[`SSC_C3_CLR_CTS];
	assign clear_underflow_cmd = wr_c3 & bus_data_in[`SSC_C3_CLR_UF];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			control_two_format_reg <= `SSC_C2_RESET;
		end else if (wr_c2) begin
			control_two_format_reg <= bus_data_in;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			control_three_sync_mode_reg <= `SSC_C3_RESET;
		end else if (wr_c3) begin
			control_three_sync_mode_reg <= bus_data_in[`SSC_C3_ONE_SYNC:`SSC_C3_EXT_SYNC];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_pattern_reg <= `SSC_SYNC_RESET;
		end else if (wr_sync) begin
			sync_pattern_reg <= bus_data_in;
		end
	end

	// Pin synchronisers
	logic rx_clk_rise;
	logic rx_clk_fall;
	logic rx_data_s;
	logic tx_clk_rise;
	logic tx_clk_fall;
	logic dcd_s;
	logic dcd_rise;
	logic cts_s;
	logic cts_rise;

	ssc_pin_sync u_rx_clk (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in(rx_clk_pin),
		.level(),
		.rise(rx_clk_rise),
		.fall(rx_clk_fall)
	);

	ssc_pin_sync u_rx_data (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in(rx_data_pin),
		.level(rx_data_s),
		.rise(),
		.fall()
	);

	ssc_pin_sync u_tx_clk (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in(tx_clk_pin),
		.level(),
		.rise(tx_clk_rise),
		.fall(tx_clk_fall)
	);

	ssc_pin_sync u_dcd (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in(carrier_detect_in),
		.level(dcd_s),
		.rise(dcd_rise),
		.fall()
	);

	ssc_pin_sync u_cts (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in(clear_to_send_in),
		.level(cts_s),
		.rise(cts_rise),
		.fall()
	);

	// Receive window, newest bit at the top
	logic [8:0] rx_sr_reg;
	logic [8:0] rx_word;
	logic sync_match;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_sr_reg <= 9'h000;
		end else if (rx_clk_rise) begin
			rx_sr_reg <= {rx_data_s, rx_sr_reg[8:1]};
		end
	end

	assign rx_word = rx_sr_reg >> (`SSC_MAX_CHAR - char_len);
	// Nine-bit format ignores the parity slot of the pattern
	assign sync_match = ((rx_word[7:0] ^ sync_pattern_reg) & bit_mask(cmp_len)) == 8'h00;

	// Receiver framing, evaluated once the completing bit's clock falls
	ssc_pkg::ssc_rx_state_t rx_state_reg;
	logic [3:0] rx_cnt_reg;
	logic [3:0] rx_cnt_next;
	logic rx_boundary;

	assign rx_cnt_next = rx_cnt_reg + 4'h1;
	assign rx_boundary = (rx_cnt_next == char_len);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_reg <= ssc_pkg::SSC_RX_HUNT;
			rx_cnt_reg <= 4'h0;
		end else if (rx_section_reset || clear_sync_in) begin
			rx_state_reg <= ssc_pkg::SSC_RX_HUNT;
			rx_cnt_reg <= 4'h0;
		end else if (ext_sync) begin
			// Plain converter framed by carrier
			if (dcd_s) begin
				rx_state_reg <= ssc_pkg::SSC_RX_HUNT;
				rx_cnt_reg <= 4'h0;
			end else if (rx_clk_fall) begin
				rx_state_reg <= ssc_pkg::SSC_RX_SYNCED;
				rx_cnt_reg <= rx_boundary ? 4'h0 : rx_cnt_next;
			end
		end else if (rx_clk_fall) begin
			case (rx_state_reg)
				ssc_pkg::SSC_RX_HUNT: begin
					rx_cnt_reg <= 4'h0;
					if (sync_match) begin
						rx_state_reg <= one_sync ? ssc_pkg::SSC_RX_SYNCED
							: ssc_pkg::SSC_RX_SECOND;
					end
				end
				ssc_pkg::SSC_RX_SECOND: begin
					rx_cnt_reg <= rx_boundary ? 4'h0 : rx_cnt_next;
					// A miss resumes the sliding search from here
					if (rx_boundary) begin
						rx_state_reg <= sync_match ? ssc_pkg::SSC_RX_SYNCED
							: ssc_pkg::SSC_RX_HUNT;
					end
				end
				ssc_pkg::SSC_RX_SYNCED: begin
					rx_cnt_reg <= rx_boundary ? 4'h0 : rx_cnt_next;
				end
				default: begin
					rx_state_reg <= ssc_pkg::SSC_RX_HUNT;
					rx_cnt_reg <= 4'h0;
				end
			endcase
		end
	end

	// Character hand-off; only framed characters reach here
	logic rx_done;
	logic [8:0] rx_expect;

	assign rx_done = rx_clk_fall && (rx_state_reg == ssc_pkg::SSC_RX_SYNCED) && rx_boundary
		&& !rx_section_reset && !clear_sync_in && !(ext_sync && dcd_s);
	assign rx_expect = build_char(rx_word[7:0], fmt);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_char_valid <= 1'b0;
			rx_char_data <= 8'h00;
			rx_char_par_err <= 1'b0;
		end else begin
			rx_char_valid <= 1'b0;
			// Sync characters that framed us never get here
			if (rx_done && !(sync_match && strip_sync_in)) begin
				rx_char_valid <= 1'b1;
				rx_char_data <= rx_word[7:0] & bit_mask(fmt.data_bits);
				rx_char_par_err <= fmt.par_en
					&& (rx_word[fmt.data_bits] != rx_expect[fmt.data_bits]);
			end
		end
	end

	// Match pulse spans one receive bit, fall to fall
	logic sm_pulse_reg;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sm_pulse_reg <= 1'b0;
		end else if (rx_section_reset) begin
			sm_pulse_reg <= 1'b0;
		end else if (rx_clk_fall) begin
			sm_pulse_reg <= sync_match;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			match_or_terminal_ready_out <= 1'b1;
		end else if (match_mode_select) begin
			match_or_terminal_ready_out <= sm_pulse_reg & ~output_level_ctl;
		end else begin
			match_or_terminal_ready_out <= ~output_level_ctl;
		end
	end

	// Transmitter: data changes on the falling tx clock
	logic [8:0] tx_sr_reg;
	logic [3:0] tx_cnt_reg;
	logic [8:0] tx_fill;
	logic [8:0] tx_load;
	logic tx_last;
	logic uf_detect;

	// Sync fill carries parity only in the nine-bit format
	assign tx_fill = !tx_sync_fill ? `SSC_MARK_CHAR
		: (char_len == `SSC_MAX_CHAR) ? build_char(sync_pattern_reg, fmt)
		: {1'b0, sync_pattern_reg};
	assign tx_load = tx_fifo_valid ? build_char(tx_fifo_data, fmt) : tx_fill;
	assign tx_last = (tx_cnt_reg == 4'h0);
	assign uf_detect = tx_clk_rise && tx_last && !tx_fifo_valid && tx_sync_fill
		&& !tx_section_reset;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sr_reg <= `SSC_MARK_CHAR;
			tx_cnt_reg <= 4'h0;
			tx_data_out <= 1'b1;
			tx_fifo_take <= 1'b0;
		end else begin
			tx_fifo_take <= 1'b0;
			if (tx_section_reset) begin
				tx_cnt_reg <= 4'h0;
				tx_data_out <= 1'b1;
			end else if (tx_clk_fall) begin
				if (tx_last) begin
					tx_data_out <= tx_load[0];
					tx_sr_reg <= tx_load >> 1;
					tx_cnt_reg <= char_len - 4'h1;
					tx_fifo_take <= tx_fifo_valid;
				end else begin
					tx_data_out <= tx_sr_reg[0];
					tx_sr_reg <= tx_sr_reg >> 1;
					tx_cnt_reg <= tx_cnt_reg - 4'h1;
				end
			end
		end
	end

	// Underflow pin high for the clock-high half of the last bit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_underflow <= 1'b0;
		end else if (uf_detect) begin
			tx_underflow <= 1'b1;
		end else if (tx_clk_fall || tx_section_reset) begin
			tx_underflow <= 1'b0;
		end
	end

	// Stored events; a set in the clearing cycle wins
	logic cts_stored_reg;
	logic dcd_stored_reg;
	logic ovr_stored_reg;
	logic uf_stored_reg;
	logic status_seen_reg;
	logic rx_seq_clear;

	assign rx_seq_clear = rx_fifo_read_stb & status_seen_reg;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			status_seen_reg <= 1'b0;
		end else if (status_read_stb) begin
			status_seen_reg <= 1'b1;
		end else if (rx_fifo_read_stb || rx_section_reset) begin
			status_seen_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_stored_reg <= 1'b0;
		end else if (cts_rise) begin
			cts_stored_reg <= 1'b1;
		end else if (clr_cts_cmd || tx_section_reset) begin
			cts_stored_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			uf_stored_reg <= 1'b0;
		end else if (uf_detect) begin
			uf_stored_reg <= 1'b1;
		end else if (clear_underflow_cmd || tx_section_reset) begin
			uf_stored_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dcd_stored_reg <= 1'b0;
		end else if (dcd_rise) begin
			dcd_stored_reg <= 1'b1;
		end else if (rx_seq_clear || rx_section_reset) begin
			dcd_stored_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_stored_reg <= 1'b0;
		end else if (rx_overrun_evt) begin
			ovr_stored_reg <= 1'b1;
		end else if (rx_seq_clear || rx_section_reset) begin
			ovr_stored_reg <= 1'b0;
		end
	end

	// Error interrupt; parity term clears as the FIFO moves on
	logic err_any;

	assign err_any = error_irq_enable & (ovr_stored_reg | dcd_stored_reg
		| rx_last_par_err | cts_stored_reg | uf_stored_reg);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			error_irq_status <= 1'b0;
			error_irq_b <= 1'b1;
		end else begin
			error_irq_status <= err_any;
			error_irq_b <= ~err_any;
		end
	end

	// Status view; stored CTS and carrier bits fall back to the live inputs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cts_status <= 1'b0;
			carrier_status <= 1'b0;
			underflow_status <= 1'b0;
			overrun_status <= 1'b0;
		end else begin
			cts_status <= cts_stored_reg | cts_s;
			carrier_status <= dcd_stored_reg | dcd_s;
			underflow_status <= uf_stored_reg;
			overrun_status <= ovr_stored_reg;
		end
	end

	// Availability flags; CTS holds off the sender only in hunt modes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_room_flag <= 1'b0;
			rx_avail_flag <= 1'b0;
		end else begin
			tx_room_flag <= !tx_section_reset && !(cts_s && !ext_sync)
				&& (one_byte ? tx_slot1_empty : (tx_slot1_empty && tx_slot2_empty));
			rx_avail_flag <= one_byte ? rx_slot3_full
				: (rx_slot3_full && rx_slot2_full);
		end
	end

endmodule // ssc_core

// file: hdl/ssc_regs.svh
// Register layout and framing figures for the sync serial control block.
// Assumes inclusion by the core only.
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// Write selects, {address control high, address control low}
`define SSC_SEL_CTRL2 2'h0
`define SSC_SEL_CTRL3 2'h1
`define SSC_SEL_SYNC 2'h2

// Control two field positions
`define SSC_C2_MATCH_MODE 0
`define SSC_C2_OUT_LEVEL 1
`define SSC_C2_ONE_BYTE 2
`define SSC_C2_WLEN_LO 3
`define SSC_C2_WLEN_HI 5
`define SSC_C2_TX_SYNC_FILL 6
`define SSC_C2_ERR_IRQ_EN 7

// Control three field positions
`define SSC_C3_EXT_SYNC 0
`define SSC_C3_ONE_SYNC 1
`define SSC_C3_CLR_CTS 2
`define SSC_C3_CLR_UF 3

// Reset values
`define SSC_C2_RESET 8'h00
`define SSC_C3_RESET 2'h0
`define SSC_SYNC_RESET 8'h00

// Character framing, in bits
`define SSC_MAX_CHAR 4'h9
`define SSC_MAX_DATA 4'h8
`define SSC_MARK_CHAR 9'h1FF

`endif

// file: hdl/ssc_pkg.sv
// Types shared by the sync serial control block.
// Assumes the register header is on the include path.
package ssc_pkg;

	// Decoded character format
	typedef struct packed {
		logic [3:0] data_bits;
		logic par_en;
		logic par_odd;
	} ssc_fmt_t;

	// Receiver framing state
	typedef enum logic [2:0] {
		SSC_RX_HUNT = 3'h1,
		SSC_RX_SECOND = 3'h2,
		SSC_RX_SYNCED = 3'h4
	} ssc_rx_state_t;

endpackage

// file: hdl/ssc_pin_sync.sv
// Two-stage synchroniser with edge detection for one pin.
// Assumes sys_clk is much faster than any pin toggles.
`timescale 1ns/100ps

module ssc_pin_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Pin
	input wire logic pin_in,
	// Synchronised view
	output logic level,
	output logic rise,
	output logic fall
);

	logic meta_reg;
	logic stable_reg;
	logic last_reg;

	// First stage feeds only the second
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= 1'b0;
			stable_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin_in;
			stable_reg <= meta_reg;
			last_reg <= stable_reg;
		end
	end

	assign level = stable_reg;
	assign rise = stable_reg & ~last_reg;
	assign fall = ~stable_reg & last_reg;

endmodule // ssc_pin_sync

// file: test/ssc_core_asserts.sv
// Concurrent checks on the ports of ssc_core, bound below.
// Assumes one-cycle bus_enable strobes and a quiet tx clock during clears.
`timescale 1ns/100ps

module ssc_core_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Host bus
	input wire logic bus_enable,
	input wire logic reg_select,
	input wire logic read_write,
	input wire logic [7:0] bus_data_in,
	input wire logic addr_ctl_low,
	input wire logic addr_ctl_high,
	// Levels watched
	input wire logic rx_slot2_full,
	input wire logic rx_slot3_full,
	input wire logic rx_section_reset,
	input wire logic clear_to_send_in,
	// Outputs watched
	input wire logic match_or_terminal_ready_out,
	input wire logic tx_underflow,
	input wire logic rx_avail_flag,
	input wire logic cts_status,
	input wire logic underflow_status,
	input wire logic error_irq_status,
	input wire logic error_irq_b
);
	logic [7:0] c2_sh;
	logic wr;
	logic c3_wr;
	assign wr = bus_enable && reg_select && !read_write;
	assign c3_wr = wr && ({addr_ctl_high, addr_ctl_low} == 2'h1);
	// Shadow of control two, rebuilt from bus traffic only
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			c2_sh <= 8'h00;
		else if (wr && ({addr_ctl_high, addr_ctl_low} == 2'h0))
			c2_sh <= bus_data_in;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_match_hold;
		match_or_terminal_ready_out [*8] ##1 match_or_terminal_ready_out [*3];
	endsequence
	sequence s_uf_high;
		tx_underflow [*5];
	endsequence
	a_level_mode_out: assert property (c2_sh == $past(c2_sh) && (c2_sh[1] || !c2_sh[0])
		|-> match_or_terminal_ready_out == !(c2_sh[1] || c2_sh[0]))
		else $error("match or ready level wrong");
	a_match_one_bit: assert property (c2_sh[1:0] == 2'h1 && $rose(match_or_terminal_ready_out)
		|-> s_match_hold ##[1:3] !match_or_terminal_ready_out)
		else $error("match pulse not one bit wide");
	a_avail_size: assert property (c2_sh == $past(c2_sh) && !rx_section_reset
		&& $stable(rx_slot2_full) && $stable(rx_slot3_full)
		|-> rx_avail_flag == (c2_sh[2] ? rx_slot3_full : rx_slot2_full && rx_slot3_full))
		else $error("receive available flag wrong");
	a_uf_gate_off: assert property (!c2_sh[6] && !$past(c2_sh[6]) |-> !$rose(tx_underflow))
		else $error("underflow pulse without sync fill");
	a_uf_pulse_len: assert property ($rose(tx_underflow) |-> s_uf_high ##[1:4] !tx_underflow)
		else $error("underflow pulse width wrong");
	a_uf_status_set: assert property ($rose(tx_underflow) |-> ##[0:2] underflow_status)
		else $error("underflow status not stored");
	a_uf_clear_cmd: assert property (c3_wr && bus_data_in[3] && !tx_underflow
		|-> ##[1:2] !underflow_status)
		else $error("underflow clear ignored");
	a_cts_clear_cmd: assert property (c3_wr && bus_data_in[2] && !clear_to_send_in
		&& !$past(clear_to_send_in, 4) |-> ##[1:2] !cts_status)
		else $error("cts clear ignored");
	a_irq_cts_on: assert property (c2_sh[7] && cts_status |-> ##[0:2] !error_irq_b)
		else $error("cts interrupt missing");
	a_irq_masked: assert property (!c2_sh[7] && !$past(c2_sh[7]) && !$past(c2_sh[7], 2)
		|-> !error_irq_status)
		else $error("interrupt status while masked");
endmodule // ssc_core_asserts

bind ssc_core ssc_core_asserts u_asserts (.*);

// file: test/ssc_line_model.sv
// Line side model: receive clock and data source, transmit clock and sampler.
// Assumes both bit clocks stand low between frames, period 64 ns.
`timescale 1ns/100ps

module ssc_line_model (
	// Transmit side
	input wire logic tx_run,
	input wire logic tx_data,
	output logic tx_clk,
	// Receive side
	output logic rx_clk,
	output logic rx_data
);
	initial begin
		tx_clk = 1'h0;
		rx_clk = 1'h0;
		rx_data = 1'h1;
	end
	// Runs only while asked, so no stray characters go out
	always begin
		wait (tx_run === 1'h1);
		#32 tx_clk = 1'h1;
		#32 tx_clk = 1'h0;
	end
	// LSB first, changed on the fall, sampled by the block on the rise
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			rx_data = b[i];
			#32 rx_clk = 1'h1;
			#32 rx_clk = 1'h0;
		end
		// Released line must not keep showing the last bit
		rx_data = ~b[7];
	endtask
	task automatic collect(input int n, output logic [8:0] v);
		v = 9'h000;
		for (int i = 0; i < n; i++)
			@(posedge tx_clk) v[i] = tx_data;
	endtask
endmodule // ssc_line_model

// file: test/sync_serial_ctrl_sync_code_tb.sv
// Self-checking bench for ssc_core with the line model on the serial side.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps

module sync_serial_ctrl_sync_code_tb;
	localparam logic [7:0] pat = 8'hE4;
	// Control two, slots {t1,t2,r2,r3}, expected {tx_room, rx_avail, out}
	localparam logic [14:0] rows [7] = '{{8'h04, 4'h9, 3'h7}, {8'h00, 4'h9, 3'h1},
		{8'h00, 4'hF, 3'h7}, {8'h06, 4'h6, 3'h0}, {8'h02, 4'hC, 3'h4}, {8'h07, 4'h3, 3'h2},
		{8'h05, 4'hA, 3'h4}};
	logic sys_clk = 1'h0;
	logic rst_b, bus_enable, reg_select, read_write, addr_ctl_low, addr_ctl_high;
	logic strip_sync_in, clear_sync_in, tx_section_reset, rx_section_reset, status_read_stb;
	logic rx_fifo_read_stb, rx_overrun_evt, rx_last_par_err, tx_slot1_empty, tx_slot2_empty;
	logic rx_slot2_full, rx_slot3_full, tx_fifo_valid, carrier_detect_in, clear_to_send_in;
	logic [7:0] bus_data_in, tx_fifo_data, rx_char_data, last_rx;
	logic rx_clk_pin, rx_data_pin, tx_clk_pin, tx_data_out, match_or_terminal_ready_out;
	logic tx_underflow, tx_room_flag, rx_avail_flag, carrier_status, cts_status;
	logic underflow_status, overrun_status, error_irq_status, error_irq_b, tx_run, m_prev;
	logic tx_fifo_take, rx_char_valid, rx_char_par_err;
	logic [8:0] v, expv;
	int n_mismatch = 0, comparisons = 0, cycles = 0, n_rx = 0, n_match = 0, m0, len;

	ssc_core dut (.*);
	ssc_line_model line (.tx_run, .tx_data(tx_data_out), .tx_clk(tx_clk_pin),
		.rx_clk(rx_clk_pin), .rx_data(rx_data_pin));

	always #2.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		m_prev <= match_or_terminal_ready_out;
		if (rx_char_valid === 1'h1) begin
			n_rx++;
			last_rx <= rx_char_data;
		end
		if (match_or_terminal_ready_out === 1'h1 && m_prev === 1'h0)
			n_match++;
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic rd = 1'h0);
		@(posedge sys_clk);
		bus_enable <= 1'h1;
		reg_select <= 1'h1;
		read_write <= rd;
		{addr_ctl_high, addr_ctl_low} <= sel;
		bus_data_in <= d;
		@(posedge sys_clk) bus_enable <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic wait_uf;
		repeat (600) if (tx_underflow !== 1'h0) @(posedge sys_clk);
		repeat (600) if (tx_underflow !== 1'h1) @(posedge sys_clk);
		check(tx_underflow, 1'h1);
	endtask

	task tally_and_finish;
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		{rst_b, bus_enable, reg_select, read_write, bus_data_in, addr_ctl_low, addr_ctl_high,
			strip_sync_in, clear_sync_in, tx_section_reset, rx_section_reset, status_read_stb,
			rx_fifo_read_stb, rx_overrun_evt, rx_last_par_err, tx_slot1_empty, tx_slot2_empty,
			rx_slot2_full, rx_slot3_full, tx_fifo_valid, tx_fifo_data, carrier_detect_in,
			clear_to_send_in, tx_run} = '0;
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (4) @(posedge sys_clk);
		check({match_or_terminal_ready_out, error_irq_b, tx_data_out, cts_status, carrier_status,
			rx_char_par_err}, 9'h038);
		// Reads and the unused select must leave control two alone
		wr(2'h0, 8'h02, 1'h1);
		wr(2'h3, 8'h02);
		wr(2'h1, 8'h02);
		wr(2'h2, 8'h02);
		check(match_or_terminal_ready_out, 1'h1);
		foreach (rows[i]) begin
			wr(2'h0, rows[i][14:7]);
			{tx_slot1_empty, tx_slot2_empty, rx_slot2_full, rx_slot3_full} <= rows[i][6:3];
			repeat (3) @(posedge sys_clk);
			check(tx_room_flag, rows[i][2]);
			check(rx_avail_flag, rows[i][1]);
			check(match_or_terminal_ready_out, rows[i][0]);
		end
		clear_to_send_in <= 1'h1;
		repeat (8) @(posedge sys_clk);
		check({cts_status, error_irq_b}, 9'h003);
		clear_to_send_in <= 1'h0;
		wr(2'h0, 8'h99);
		repeat (3) @(posedge sys_clk);
		check(error_irq_b, 1'h0);
		wr(2'h1, 8'h00);
		check(error_irq_b, 1'h0);
		wr(2'h1, 8'h04);
		repeat (2) @(posedge sys_clk);
		check({cts_status, error_irq_b}, 9'h001);
		rx_overrun_evt <= 1'h1;
		@(posedge sys_clk) rx_overrun_evt <= 1'h0;
		repeat (3) @(posedge sys_clk);
		check({overrun_status, error_irq_b}, 9'h002);
		// A FIFO read alone is not enough; status read must come first
		rx_fifo_read_stb <= 1'h1;
		@(posedge sys_clk) rx_fifo_read_stb <= 1'h0;
		@(posedge sys_clk) status_read_stb <= 1'h1;
		@(posedge sys_clk) status_read_stb <= 1'h0;
		repeat (3) @(posedge sys_clk);
		check(error_irq_b, 1'h0);
		rx_fifo_read_stb <= 1'h1;
		@(posedge sys_clk) rx_fifo_read_stb <= 1'h0;
		repeat (3) @(posedge sys_clk);
		check({overrun_status, error_irq_b}, 9'h001);
		rx_last_par_err <= 1'h1;
		repeat (3) @(posedge sys_clk);
		check(error_irq_b, 1'h0);
		rx_last_par_err <= 1'h0;
		repeat (3) @(posedge sys_clk);
		check(error_irq_b, 1'h1);
		// Sync fill in every word length
		wr(2'h2, pat);
		tx_run <= 1'h1;
		for (int c = 0; c < 8; c++) begin
			wr(2'h0, {2'h3, c[2:0], 3'h0});
			len = (c < 3) ? 7 : (c < 6) ? 8 : 9;
			expv = (len == 9) ? {^pat ^ c[0], pat} : {1'h0, pat} & ((9'h001 << len) - 9'h001);
			wait_uf();
			wait_uf();
			line.collect(len, v);
			check(v, expv);
		end
		check({underflow_status, error_irq_b}, 9'h002);
		wr(2'h0, 8'h18);
		line.collect(9, v);
		line.collect(9, v);
		check(v, 9'h1FF);
		tx_run <= 1'h0;
		repeat (40) @(posedge sys_clk);
		wr(2'h0, 8'h98);
		wr(2'h1, 8'h00);
		check(underflow_status, 1'h1);
		wr(2'h1, 8'h08);
		repeat (2) @(posedge sys_clk);
		check({underflow_status, error_irq_b}, 9'h001);
		// Receive: one sync character, then strip on and off
		wr(2'h0, 8'h99);
		wr(2'h1, 8'h02);
		m0 = n_match;
		line.send(pat);
		line.send(8'h3C);
		repeat (20) @(posedge sys_clk);
		check(n_rx, 1);
		check(last_rx, 8'h3C);
		check(n_match - m0, 1);
		strip_sync_in <= 1'h1;
		line.send(pat);
		line.send(8'h5A);
		repeat (20) @(posedge sys_clk);
		check({n_rx[1:0], last_rx}, {2'h2, 8'h5A});
		strip_sync_in <= 1'h0;
		line.send(pat);
		line.send(8'h5A);
		repeat (20) @(posedge sys_clk);
		check({n_rx[1:0], last_rx}, {2'h0, 8'h5A});
		// Inhibited sync still reports matches
		clear_sync_in <= 1'h1;
		m0 = n_match;
		line.send(pat);
		line.send(8'h00);
		repeat (20) @(posedge sys_clk);
		check(n_match - m0, 1);
		check(n_rx, 4);
		// Two sync characters, with a miss after the first
		clear_sync_in <= 1'h0;
		wr(2'h1, 8'h00);
		line.send(pat);
		line.send(8'h00);
		line.send(pat);
		line.send(pat);
		line.send(8'h81);
		repeat (20) @(posedge sys_clk);
		check({n_rx[1:0], last_rx}, {2'h1, 8'h81});
		tally_and_finish();
	end
endmodule // sync_serial_ctrl_sync_code_tb
